// ---- logic/usb_irq_pkg.sv ----
// Purpose: shared constants of the usb interrupt flag block
// Assumes: 32-bit bus words, one register per word, index * 4 = byte address
// Notes:   all register widths are 8 bits, upper bits read as zero
`default_nettype none

package usb_irq_pkg;

  // ************************************************************
  // register indices
  // ************************************************************
  localparam logic [5:0] IDX_POWER = 6'h01;
  localparam logic [5:0] IDX_IN_FLAGS = 6'h02;
  localparam logic [5:0] IDX_OUT_FLAGS = 6'h04;
  localparam logic [5:0] IDX_CM_FLAGS = 6'h06;
  localparam logic [5:0] IDX_IN_EN = 6'h07;
  localparam logic [5:0] IDX_OUT_EN = 6'h09;
  localparam logic [5:0] IDX_CM_EN = 6'h0B;
  localparam logic [5:0] IDX_CORE_EN = 6'h10;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h11;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CM_SOF = 3;
  localparam int CM_BUS_RESET = 2;
  localparam int CM_WAKE = 1;
  localparam int CM_SLEEP = 0;
  localparam int PWR_SLEEP_DETECT_EN = 0;
  localparam int PWR_SLEEP_STATE = 1;
  localparam int PWR_FORCE_RESUME = 2;

  // ************************************************************
  // reset values and valid bit masks
  // ************************************************************
  localparam logic [3:0] IN_EN_RESET = 4'hF;
  localparam logic [3:0] OUT_EN_RESET = 4'hE;
  localparam logic [3:0] CM_EN_RESET = 4'hE;
  localparam logic [3:0] IN_FLAG_MASK = 4'hF;
  localparam logic [3:0] OUT_FLAG_MASK = 4'hE;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int FRAME_PERIOD_US = 1000;
  localparam int FRAME_CYCLES = FRAME_PERIOD_US * CLK_MHZ;

endpackage : usb_irq_pkg

`default_nettype wire

// ---- logic/ahb_reg_port.sv ----
// Purpose: ahb-lite slave front end, zero wait states, always okay
// Assumes: single word transfers only
// Notes:   read strobe in address phase, write strobe in data phase
`default_nettype none

module ahb_reg_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic rd_stb,
  output logic [5:0] rd_idx,
  output logic rd_mapped,
  output logic wr_stb,
  output logic [5:0] wr_idx
);

  logic take;
  logic mapped;

  assign take = hsel && hready && htrans[1];
  assign mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_stb = take && !hwrite && mapped;
  assign rd_idx = haddr[7:2];
  assign rd_mapped = mapped;

  // ************************************************************
  // write data phase follows the accepted address phase
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_stb <= 1'b0;
      wr_idx <= 6'h00;
    end else begin
      wr_stb <= take && hwrite && mapped;
      if (take) begin
        wr_idx <= haddr[7:2];
      end
    end
  end

endmodule : ahb_reg_port

`default_nettype wire

// ---- logic/frame_watchdog.sv ----
// Purpose: frame period timer that stands in for lost frame tokens
// Assumes: tokens arrive as one-cycle pulses on hclk
// Notes:   armed by the first real token, disarmed by bus reset
`default_nettype none

module frame_watchdog #(
  parameter int FRAME_CYCLES = usb_irq_pkg::FRAME_CYCLES,
  parameter int CNT_W = 17
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sof_token,
  input wire logic bus_reset_detect,
  output logic sof_event
);

  logic armed;
  logic [CNT_W-1:0] cnt;
  logic expire;

  assign expire = armed && (cnt == CNT_W'(FRAME_CYCLES - 1));
  assign sof_event = sof_token || (expire && !bus_reset_detect);

  // ************************************************************
  // frame counter
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed <= 1'b0;
      cnt <= '0;
    end else if (bus_reset_detect) begin
      armed <= 1'b0;
      cnt <= '0;
    end else if (sof_token || expire) begin
      armed <= 1'b1;
      cnt <= '0;
    end else if (armed) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

endmodule : frame_watchdog

`default_nettype wire

// ---- logic/usb_function_irq_flags.sv ----
// Purpose: interrupt flags and enables of a usb function controller
// Assumes: event inputs are one-cycle pulses on hclk
// Notes:   flag registers clear on read, read data is taken at the
//          address phase so the clear and the returned value agree
//
// Notes on behaviour
// RULE1 - any enabled flag raises the usb request
// RULE2 - reading a flag register returns then clears
// RULE3 - flag registers ignore all writes
// RULE4 - core enable bit gates request to processor
// RULE5 - in flags: ep3..ep1 bits 3..1, control bit0
// RULE6 - in flags bits 7..4 read zero
// RULE7 - out flags bits 3..1, others read zero
// RULE8 - frame token sets common bit 3
// RULE9 - frame timer synthesizes missing frame events
// RULE10 - bus reset sets common bit 2
// RULE11 - resume sets bit 1 only while asleep
// RULE12 - suspend sets bit 0 only if detection enabled
// RULE13 - in enables bits 3..0, reset all on
// RULE14 - flag counts only while its enable set
// RULE15 - bus reset clears flags, enables all but suspend
// RULE16 - ending forced resume interrupts and clears sleep
//
// Design decision made here: the AHB-Lite slave port.
`default_nettype none

module usb_function_irq_flags #(
  parameter int FRAME_CYCLES = usb_irq_pkg::FRAME_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] in_ep_event,
  input wire logic [3:0] out_ep_event,
  input wire logic sof_token,
  input wire logic bus_reset_detect,
  input wire logic resume_detect,
  input wire logic suspend_detect,
  output logic usb_irq_req,
  output logic irq,
  output logic sleep_state,
  output logic force_resume
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic rd_stb;
  logic [5:0] rd_idx;
  logic rd_mapped;
  logic wr_stb;
  logic [5:0] wr_idx;
  logic sof_event;
  logic [3:0] in_flags;
  logic [3:0] out_flags;
  logic [3:0] cm_flags;
  logic [3:0] in_en;
  logic [3:0] out_en;
  logic [3:0] cm_en;
  logic sleep_detect_en;
  logic core_en;
  logic irq_stat;
  logic [3:0] next_in_flags;
  logic [3:0] next_out_flags;
  logic [3:0] next_cm_flags;
  logic [3:0] cm_set;
  logic rd_in;
  logic rd_out;
  logic rd_cm;
  logic wr_hit_power;
  logic resume_end;
  logic [7:0] rd_value;

  function automatic logic wr_to(input logic [5:0] idx);
    wr_to = wr_stb && (wr_idx == idx);
  endfunction : wr_to

  function automatic logic rd_of(input logic [5:0] idx);
    rd_of = rd_stb && (rd_idx == idx);
  endfunction : rd_of

  ahb_reg_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_stb(rd_stb),
    .rd_idx(rd_idx),
    .rd_mapped(rd_mapped),
    .wr_stb(wr_stb),
    .wr_idx(wr_idx)
  );

  frame_watchdog #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_frame (
    .hclk(hclk),
    .hresetn(hresetn),
    .sof_token(sof_token),
    .bus_reset_detect(bus_reset_detect),
    .sof_event(sof_event) // [RULE9]
  );

  // ************************************************************
  // flag set and clear terms
  // ************************************************************
  assign rd_in = rd_of(usb_irq_pkg::IDX_IN_FLAGS);
  assign rd_out = rd_of(usb_irq_pkg::IDX_OUT_FLAGS);
  assign rd_cm = rd_of(usb_irq_pkg::IDX_CM_FLAGS);
  assign wr_hit_power = wr_to(usb_irq_pkg::IDX_POWER);
  assign resume_end = wr_hit_power && force_resume
    && !hwdata[usb_irq_pkg::PWR_FORCE_RESUME];

  always_comb begin
    cm_set = 4'h0;
    cm_set[usb_irq_pkg::CM_SOF] = sof_event; // [RULE8] [RULE9]
    cm_set[usb_irq_pkg::CM_BUS_RESET] = bus_reset_detect; // [RULE10]
    cm_set[usb_irq_pkg::CM_WAKE] = (resume_detect && sleep_state)
      || resume_end; // [RULE11] [RULE16]
    cm_set[usb_irq_pkg::CM_SLEEP] = suspend_detect
      && sleep_detect_en; // [RULE12]
  end

  // a set in the same cycle as the read clear wins
  always_comb begin
    next_in_flags = (rd_in ? 4'h0 : in_flags)
      | (in_ep_event & usb_irq_pkg::IN_FLAG_MASK); // [RULE2] [RULE5]
    next_out_flags = (rd_out ? 4'h0 : out_flags)
      | (out_ep_event & usb_irq_pkg::OUT_FLAG_MASK); // [RULE2] [RULE7]
    next_cm_flags = (rd_cm ? 4'h0 : cm_flags) | cm_set; // [RULE2]
    if (bus_reset_detect) begin
      next_in_flags = usb_irq_pkg::FLAGS_RESET; // [RULE15]
      next_out_flags = usb_irq_pkg::FLAGS_RESET;
      next_cm_flags = 4'h0;
      next_cm_flags[usb_irq_pkg::CM_BUS_RESET] = 1'b1;
    end
  end

  // ************************************************************
  // flag registers, no write path
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_flags <= usb_irq_pkg::FLAGS_RESET;
      out_flags <= usb_irq_pkg::FLAGS_RESET;
      cm_flags <= usb_irq_pkg::FLAGS_RESET;
    end else begin
      in_flags <= next_in_flags; // [RULE3]
      out_flags <= next_out_flags; // [RULE3]
      cm_flags <= next_cm_flags; // [RULE3]
    end
  end

  // ************************************************************
  // enable registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_en <= usb_irq_pkg::IN_EN_RESET; // [RULE13]
      out_en <= usb_irq_pkg::OUT_EN_RESET;
      cm_en <= usb_irq_pkg::CM_EN_RESET;
    end else if (bus_reset_detect) begin
      in_en <= usb_irq_pkg::IN_EN_RESET; // [RULE15]
      out_en <= usb_irq_pkg::OUT_EN_RESET;
      cm_en <= usb_irq_pkg::CM_EN_RESET;
    end else begin
      if (wr_to(usb_irq_pkg::IDX_IN_EN)) begin
        in_en <= hwdata[3:0]; // [RULE13]
      end
      if (wr_to(usb_irq_pkg::IDX_OUT_EN)) begin
        out_en <= hwdata[3:0] & usb_irq_pkg::OUT_FLAG_MASK;
      end
      if (wr_to(usb_irq_pkg::IDX_CM_EN)) begin
        cm_en <= hwdata[3:0];
      end
    end
  end

  // ************************************************************
  // power control and sleep state
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_detect_en <= 1'b0;
      force_resume <= 1'b0;
    end else if (wr_hit_power) begin
      sleep_detect_en <= hwdata[usb_irq_pkg::PWR_SLEEP_DETECT_EN];
      force_resume <= hwdata[usb_irq_pkg::PWR_FORCE_RESUME];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_state <= 1'b0;
    end else if (bus_reset_detect || resume_end) begin
      sleep_state <= 1'b0; // [RULE16]
    end else if (rd_cm && cm_flags[usb_irq_pkg::CM_WAKE]) begin
      sleep_state <= 1'b0;
    end else if (suspend_detect && sleep_detect_en) begin
      sleep_state <= 1'b1;
    end
  end

  // ************************************************************
  // combined request and core interrupt
  // ************************************************************
  assign usb_irq_req = |(in_flags & in_en) | |(out_flags & out_en)
    | |(cm_flags & cm_en); // [RULE1] [RULE14]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_en <= 1'b0;
    end else if (wr_to(usb_irq_pkg::IDX_CORE_EN)) begin
      core_en <= hwdata[0];
    end
  end

  // sticky copy of the request, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= 1'b0;
    end else if (usb_irq_req) begin
      irq_stat <= 1'b1;
    end else if (wr_to(usb_irq_pkg::IDX_IRQ_STAT) && hwdata[0]) begin
      irq_stat <= 1'b0;
    end
  end

  assign irq = irq_stat && core_en; // [RULE4]

  // ************************************************************
  // read mux and read data register
  // ************************************************************
  always_comb begin
    rd_value = 8'h00;
    if (!rd_mapped) begin
      rd_value = 8'h00;
    end else if (rd_idx == usb_irq_pkg::IDX_POWER) begin
      rd_value = {5'h00, force_resume, sleep_state, sleep_detect_en};
    end else if (rd_idx == usb_irq_pkg::IDX_IN_FLAGS) begin
      rd_value = {4'h0, in_flags}; // [RULE5] [RULE6]
    end else if (rd_idx == usb_irq_pkg::IDX_OUT_FLAGS) begin
      rd_value = {4'h0, out_flags}; // [RULE7]
    end else if (rd_idx == usb_irq_pkg::IDX_CM_FLAGS) begin
      rd_value = {4'h0, cm_flags};
    end else if (rd_idx == usb_irq_pkg::IDX_IN_EN) begin
      rd_value = {4'h0, in_en};
    end else if (rd_idx == usb_irq_pkg::IDX_OUT_EN) begin
      rd_value = {4'h0, out_en};
    end else if (rd_idx == usb_irq_pkg::IDX_CM_EN) begin
      rd_value = {4'h0, cm_en};
    end else if (rd_idx == usb_irq_pkg::IDX_CORE_EN) begin
      rd_value = {7'h00, core_en};
    end else if (rd_idx == usb_irq_pkg::IDX_IRQ_STAT) begin
      rd_value = {7'h00, irq_stat};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_stb) begin
      hrdata <= {24'h000000, rd_value};
    end else if (hsel && hready && htrans[1]) begin
      hrdata <= 32'h00000000;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  logic unused_hsize;
  assign unused_hsize = ^hsize;

  a_req_from_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(in_flags & in_en)) |-> usb_irq_req) // [RULE1]
    else $error("enabled in flag without usb request");

  a_read_clears_in: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_in && !bus_reset_detect && in_ep_event == 4'h0
    |=> in_flags == 4'h0 && hrdata[3:0] == $past(in_flags)) // [RULE2]
    else $error("in flag read did not return then clear");

  a_read_other_kept: assert property (@(posedge hclk)
    disable iff (!hresetn)
    rd_in && !bus_reset_detect |=> (out_flags & $past(out_flags))
    == $past(out_flags)) // [RULE2]
    else $error("reading in flags disturbed out flags");

  a_write_no_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_to(usb_irq_pkg::IDX_IN_FLAGS) && !rd_in && !bus_reset_detect
    && in_ep_event == 4'h0 |=> in_flags == $past(in_flags)) // [RULE3]
    else $error("write changed in flags");

  a_core_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    usb_irq_req && core_en && !wr_to(usb_irq_pkg::IDX_CORE_EN)
    |=> irq) // [RULE4]
    else $error("usb request did not reach core");

  a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(rd_in) |-> hrdata[31:4] == 28'h0000000) // [RULE6]
    else $error("in flag upper bits not zero");

  a_out_bit0: assert property (@(posedge hclk) disable iff (!hresetn)
    out_flags[0] == 1'b0) // [RULE7]
    else $error("out flag bit 0 set");

  a_sof_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    sof_token && !bus_reset_detect |=> cm_flags[usb_irq_pkg::CM_SOF])
    // [RULE8]
    else $error("frame token did not set flag");

  a_reset_effect: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_reset_detect |=> cm_flags == 4'h4 && in_flags == 4'h0
    && in_en == 4'hF && cm_en[usb_irq_pkg::CM_SLEEP] == 1'b0)
    // [RULE10] [RULE15]
    else $error("bus reset effect wrong");

  a_wake_asleep: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(cm_flags[usb_irq_pkg::CM_WAKE])
    |-> $past(sleep_state) || $past(resume_end)) // [RULE11]
    else $error("wake flag set while awake");

  a_sleep_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    suspend_detect && !sleep_detect_en && !rd_cm && !bus_reset_detect
    && !cm_flags[usb_irq_pkg::CM_SLEEP]
    |=> !cm_flags[usb_irq_pkg::CM_SLEEP]) // [RULE12]
    else $error("suspend flag set with detection off");

  a_enable_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    ((in_flags & in_en) == 4'h0) && ((out_flags & out_en) == 4'h0)
    && ((cm_flags & cm_en) == 4'h0) |-> !usb_irq_req) // [RULE14]
    else $error("request without enabled flag");

  a_resume_end: assert property (@(posedge hclk) disable iff (!hresetn)
    resume_end && !bus_reset_detect
    |=> !sleep_state && cm_flags[usb_irq_pkg::CM_WAKE]) // [RULE16]
    else $error("ending forced resume had no effect");

  c_read_clear: cover property (@(posedge hclk) disable iff (!hresetn)
    rd_cm && cm_flags != 4'h0);
  c_irq_out: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(irq));
  c_sleep_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    sleep_state ##[1:50] resume_detect);
  c_synth_sof: cover property (@(posedge hclk) disable iff (!hresetn)
    sof_event && !sof_token);

endmodule : usb_function_irq_flags

`default_nettype wire

// ---- sim/ahb_master.sv ----
// Purpose: ahb-lite master standing in for the processor software
// Assumes: single word transfers, one slave whose hreadyout is hready
// Notes:   released data and address lines show the inverse of their value
`default_nettype none

module ahb_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic timed_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    timed_out = 1'b0;
  end

  // waits for hready high at a rising edge, bounded
  task automatic wait_ready();
    for (int i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) return;
    end
    timed_out <= 1'b1;
  endtask : wait_ready

  task automatic xfer(input logic wr, input logic [31:0] addr,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    haddr <= ~addr;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    hwdata <= ~wd;
  endtask : xfer
endmodule : ahb_master

`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: self-checking bench of the usb interrupt flag block
// Assumes: short frame period, events are one-cycle pulses
// Notes:   expectations come from a small register model below
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FRAME = 20;
  logic hclk, hresetn, hsel, hwrite, hready, timed_out;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] in_ep_event, out_ep_event;
  logic sof_token, bus_reset_detect, resume_detect, suspend_detect;
  logic usb_irq_req, irq, sleep_state, force_resume, hresp;
  int n_errors, tests_run;
  int m_in, m_out, m_cm, m_in_en, m_out_en, m_cm_en, m_pwr, m_sleep;

  usb_function_irq_flags #(.FRAME_CYCLES(FRAME)) DUT (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .in_ep_event(in_ep_event), .out_ep_event(out_ep_event),
    .sof_token(sof_token), .bus_reset_detect(bus_reset_detect),
    .resume_detect(resume_detect), .suspend_detect(suspend_detect),
    .usb_irq_req(usb_irq_req), .irq(irq), .sleep_state(sleep_state),
    .force_resume(force_resume));
  ahb_master m (.hclk(hclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .timed_out(timed_out));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ************************************************************
  // compare and report
  // ************************************************************
  task automatic chk(input string nm, input int e, input logic [31:0] g);
    tests_run++;
    if (g !== 32'(e)) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  function automatic logic req_exp();
    return ((m_in & m_in_en) | (m_out & m_out_en) | (m_cm & m_cm_en)) != 0;
  endfunction : req_exp

  // ************************************************************
  // bus and event drivers with model update
  // ************************************************************
  task automatic rd(input logic [5:0] ix, input string nm);
    logic [31:0] g;
    int e;
    case (ix)
      usb_irq_pkg::IDX_IN_FLAGS: e = m_in;
      usb_irq_pkg::IDX_OUT_FLAGS: e = m_out;
      usb_irq_pkg::IDX_CM_FLAGS: e = m_cm;
      usb_irq_pkg::IDX_IN_EN: e = m_in_en;
      usb_irq_pkg::IDX_OUT_EN: e = m_out_en;
      usb_irq_pkg::IDX_CM_EN: e = m_cm_en;
      usb_irq_pkg::IDX_POWER: e = m_pwr | (m_sleep << 1);
      default: e = 0;
    endcase
    m.xfer(1'b0, {24'h0, ix, 2'h0}, 32'hA5A5A5A5, g);
    chk(nm, e, g);
    chk_bit("hresp", 1'b0, hresp);
    if (ix == usb_irq_pkg::IDX_IN_FLAGS) m_in = 0;
    if (ix == usb_irq_pkg::IDX_OUT_FLAGS) m_out = 0;
    if (ix == usb_irq_pkg::IDX_CM_FLAGS) begin
      if ((m_cm & 2) != 0) m_sleep = 0;
      m_cm = 0;
    end
  endtask : rd

  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    logic [31:0] g;
    m.xfer(1'b1, {24'h0, ix, 2'h0}, {24'h0, d}, g);
    if (ix == usb_irq_pkg::IDX_IN_EN) m_in_en = d & 8'h0F;
    if (ix == usb_irq_pkg::IDX_CM_EN) m_cm_en = d & 8'h0F;
    if (ix == usb_irq_pkg::IDX_OUT_EN) m_out_en = d & 8'h0E;
    if (ix == usb_irq_pkg::IDX_POWER) begin
      if (m_pwr[2] && !d[2]) begin
        m_cm |= 2;
        m_sleep = 0;
      end
      m_pwr = d & 8'h05;
    end
    #1;
  endtask : wr

  // c: bit3 frame token, bit2 bus reset, bit1 resume, bit0 suspend
  task automatic ev(input logic [3:0] i, input logic [3:0] o,
                    input logic [3:0] c);
    @(posedge hclk);
    {in_ep_event, out_ep_event} <= {i, o};
    {sof_token, bus_reset_detect, resume_detect, suspend_detect} <= c;
    @(posedge hclk);
    {in_ep_event, out_ep_event} <= 8'h00;
    {sof_token, bus_reset_detect, resume_detect, suspend_detect} <= 4'h0;
    m_in |= i;
    m_out |= o & 4'hE;
    if (c[3]) m_cm |= 8;
    if (c[1] && m_sleep != 0) m_cm |= 2;
    if (c[0] && m_pwr[0]) begin
      m_cm |= 1;
      m_sleep = 1;
    end
    if (c[2]) begin
      {m_in, m_out, m_cm, m_sleep} = {32'd0, 32'd0, 32'd4, 32'd0};
      {m_in_en, m_out_en, m_cm_en} = {32'd15, 32'd14, 32'd14};
    end
    #1;
    chk_bit("usb_irq_req", req_exp(), usb_irq_req);
  endtask : ev

  always @(posedge timed_out) begin
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge hclk);
    n_errors++;
    finish_test();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    logic [3:0] ri, ro;
    {hresetn, in_ep_event, out_ep_event} = 9'h0;
    {sof_token, bus_reset_detect, resume_detect, suspend_detect} = 4'h0;
    {n_errors, tests_run} = {32'd0, 32'd0};
    {m_in, m_out, m_cm, m_pwr, m_sleep} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0};
    {m_in_en, m_out_en, m_cm_en} = {32'd15, 32'd14, 32'd14};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(32'hBA5C127E));
    rd(usb_irq_pkg::IDX_IN_EN, "in_en");
    rd(usb_irq_pkg::IDX_OUT_EN, "out_en");
    rd(usb_irq_pkg::IDX_CM_EN, "cm_en");
    rd(usb_irq_pkg::IDX_CM_FLAGS, "cm_flags");
    rd(6'h3F, "unmapped");
    $display("test reset_values done");
    for (int k = 0; k < 4; k++) begin
      ri = (k == 0) ? 4'hF : 4'($urandom_range(1, 15));
      ro = (k == 0) ? 4'hF : 4'($urandom_range(1, 15));
      ev(ri, ro, 4'h0);
      rd(usb_irq_pkg::IDX_OUT_FLAGS, "out_flags");
      rd(usb_irq_pkg::IDX_IN_FLAGS, "in_flags");
      rd(usb_irq_pkg::IDX_IN_FLAGS, "in_cleared");
      rd(usb_irq_pkg::IDX_OUT_FLAGS, "out_cleared");
    end
    $display("test endpoint_flags done");
    ev(4'hF, 4'h0, 4'h0);
    wr(usb_irq_pkg::IDX_IN_FLAGS, 8'hFF);
    wr(usb_irq_pkg::IDX_IN_FLAGS, 8'h00);
    rd(usb_irq_pkg::IDX_IN_FLAGS, "in_after_write");
    wr(usb_irq_pkg::IDX_IN_EN, 8'hF0);
    ev(4'h2, 4'h0, 4'h0);
    rd(usb_irq_pkg::IDX_IN_EN, "in_en_written");
    rd(usb_irq_pkg::IDX_IN_FLAGS, "masked_flag");
    wr(usb_irq_pkg::IDX_IN_EN, 8'h0F);
    $display("test write_and_mask done");
    wr(usb_irq_pkg::IDX_CORE_EN, 8'h01);
    wr(usb_irq_pkg::IDX_IRQ_STAT, 8'h01);
    chk_bit("irq", 1'b0, irq);
    ev(4'h1, 4'h0, 4'h0);
    @(posedge hclk);
    #1;
    chk_bit("irq", 1'b1, irq);
    wr(usb_irq_pkg::IDX_CORE_EN, 8'h00);
    chk_bit("irq", 1'b0, irq);
    rd(usb_irq_pkg::IDX_IN_FLAGS, "in_flags");
    wr(usb_irq_pkg::IDX_CORE_EN, 8'h01);
    wr(usb_irq_pkg::IDX_IRQ_STAT, 8'h01);
    chk_bit("irq", 1'b0, irq);
    $display("test core_enable done");
    ev(4'h0, 4'h0, 4'h8);
    rd(usb_irq_pkg::IDX_CM_FLAGS, "sof_token");
    repeat (FRAME + 5) @(posedge hclk);
    m_cm |= 8;
    rd(usb_irq_pkg::IDX_CM_FLAGS, "sof_made");
    wr(usb_irq_pkg::IDX_IN_EN, 8'h00);
    wr(usb_irq_pkg::IDX_CM_EN, 8'h00);
    wr(usb_irq_pkg::IDX_OUT_EN, 8'h00);
    rd(usb_irq_pkg::IDX_OUT_EN, "out_en_written");
    ev(4'h8, 4'h0, 4'h0);
    ev(4'h0, 4'h0, 4'h4);
    rd(usb_irq_pkg::IDX_IN_EN, "in_en_bus_reset");
    rd(usb_irq_pkg::IDX_CM_EN, "cm_en_bus_reset");
    rd(usb_irq_pkg::IDX_OUT_EN, "out_en_bus_reset");
    rd(usb_irq_pkg::IDX_IN_FLAGS, "in_bus_reset");
    rd(usb_irq_pkg::IDX_CM_FLAGS, "cm_bus_reset");
    $display("test frame_and_bus_reset done");
    ev(4'h0, 4'h0, 4'h1);
    rd(usb_irq_pkg::IDX_CM_FLAGS, "sleep_off");
    wr(usb_irq_pkg::IDX_POWER, 8'h01);
    ev(4'h0, 4'h0, 4'h1);
    chk_bit("sleep_state", 1'b1, sleep_state);
    rd(usb_irq_pkg::IDX_CM_FLAGS, "sleep_on");
    ev(4'h0, 4'h0, 4'h2);
    rd(usb_irq_pkg::IDX_CM_FLAGS, "wake_asleep");
    chk_bit("sleep_state", 1'b0, sleep_state);
    ev(4'h0, 4'h0, 4'h2);
    rd(usb_irq_pkg::IDX_CM_FLAGS, "wake_awake");
    ev(4'h0, 4'h0, 4'h1);
    rd(usb_irq_pkg::IDX_CM_FLAGS, "sleep_again");
    wr(usb_irq_pkg::IDX_POWER, 8'h05);
    chk_bit("force_resume", 1'b1, force_resume);
    wr(usb_irq_pkg::IDX_POWER, 8'h01);
    chk_bit("sleep_state", 1'b0, sleep_state);
    chk_bit("usb_irq_req", req_exp(), usb_irq_req);
    rd(usb_irq_pkg::IDX_CM_FLAGS, "resume_end");
    $display("test sleep_and_wake done");
    finish_test();
  end
endmodule : testbench

`default_nettype wire
